// ---- core/sip_pin_sync.sv ----
// Two-stage synchroniser for the SCL and SDA pin levels.
// Assumes asynchronous pin inputs and the system clock.
`timescale 1ns/1ps
`default_nettype none
module sip_pin_sync
  import sip_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Pins
  input wire sip_pins_s pins_raw,
  output var sip_pins_s pins_sync
);

  sip_pins_s meta_reg;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      meta_reg <= '1;
      pins_sync <= '1;
    end
    else
    begin
      meta_reg <= pins_raw;
      pins_sync <= meta_reg;
    end
  end

endmodule
`default_nettype wire

// ---- core/sip_pkg.sv ----
// Shared constants, types and field layout of the sensor I2C register port.
// Assumes one 100 MHz system clock and a bus master that keeps the I2C speed limits.
package sip_pkg;

  // System clock and bus speeds
  localparam int unsigned CLK_FREQ_KHZ = 100000;
  localparam int unsigned SCL_STD_MAX_KHZ = 100;
  localparam int unsigned SCL_FAST_MAX_KHZ = 400;
  localparam int unsigned SCL_MIN_PERIOD_CYC = CLK_FREQ_KHZ / SCL_FAST_MAX_KHZ;

  // Target address and pointer
  localparam logic [6:0] TARGET_ADDR = 7'h32;
  localparam int unsigned PTR_W = 8;
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [7:0] PTR_STEP = 8'h01;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // Driver check bytes
  localparam logic [7:0] SCRATCH_FIRST = 8'h88;
  localparam logic [7:0] SCRATCH_LAST = 8'h8B;
  localparam logic [7:0] RAM_RESET = 8'h00;

  // Read-only factory region and its fields
  localparam logic [7:0] NVM_BASE = 8'h00;
  localparam int unsigned NVM_BYTES = 32;
  localparam logic [7:0] NVM_CAL_COND_OFS = 8'h00;
  localparam logic [7:0] NVM_TRACK_ID_OFS = 8'h04;
  localparam logic [7:0] NVM_RESIST_OFS = 8'h08;
  localparam logic [7:0] NVM_SLOPE_OFS = 8'h10;
  localparam logic [7:0] NVM_ICEPT_OFS = 8'h18;

  typedef struct packed {
    logic scl;
    logic sda;
  } sip_pins_s;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_PTR,
    ST_PTR_ACK,
    ST_WDATA,
    ST_WDATA_ACK,
    ST_RDATA,
    ST_RACK,
    ST_IGNORE
  } sip_state_e;

endpackage

// ---- core/sip_port.sv ----
// I2C target register port: address match, pointer, burst write and read.
// Assumes open-drain SCL/SDA pins resolved outside and a 100 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module sip_port
  import sip_pkg::*;
#(
  parameter logic [6:0] OWN_ADDR = TARGET_ADDR,
  parameter logic [NVM_BYTES*8-1:0] NVM_IMAGE = '0
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // I2C pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // Status
  output logic selected
);

  sip_pins_s pins_s;
  sip_pins_s pins_q;
  sip_state_e state_reg;
  sip_state_e state_next;
  logic [3:0] bitcnt_reg;
  logic [3:0] bitcnt_next;
  logic [7:0] shift_reg;
  logic [7:0] shift_next;
  logic [7:0] tx_reg;
  logic [7:0] tx_next;
  logic [7:0] ptr_reg;
  logic [7:0] ptr_next;
  logic oe_reg;
  logic oe_next;
  logic ack_reg;
  logic ack_next;
  logic wr_en;
  logic [7:0] rd_data;

  // Sampling at 100 MHz leaves ample margin for 400 kHz SCL
  sip_pin_sync u_sync (
    .clk(clk),
    .reset(reset),
    .pins_raw({scl_i, sda_i}),
    .pins_sync(pins_s)
  );

  sip_reg_store #(
    .NVM_SIZE(NVM_BYTES),
    .NVM_IMAGE(NVM_IMAGE)
  ) u_store (
    .clk(clk),
    .reset(reset),
    .wr_en(wr_en),
    .wr_addr(ptr_reg),
    .wr_data(shift_reg),
    .rd_addr(ptr_reg),
    .rd_data(rd_data)
  );

  wire scl_rise = pins_s.scl & ~pins_q.scl;
  wire scl_fall = ~pins_s.scl & pins_q.scl;
  wire start_det = pins_s.scl & pins_q.scl & pins_q.sda & ~pins_s.sda;
  wire stop_det = pins_s.scl & pins_q.scl & ~pins_q.sda & pins_s.sda;
  wire byte_done = (bitcnt_reg == BITS_PER_BYTE);
  wire addr_match = (shift_reg[7:1] == OWN_ADDR);
  wire rw_read = shift_reg[0];
  wire [7:0] ptr_inc = ptr_reg + PTR_STEP;
  wire rd_msb = rd_data[7];

  assign sda_o = 1'b0;
  assign sda_oe = oe_reg;
  assign selected = (state_reg != ST_IDLE) && (state_reg != ST_IGNORE) &&
                    (state_reg != ST_ADDR);

  always_comb
  begin
    state_next = state_reg;
    bitcnt_next = bitcnt_reg;
    shift_next = shift_reg;
    tx_next = tx_reg;
    ptr_next = ptr_reg;
    oe_next = oe_reg;
    ack_next = ack_reg;
    wr_en = 1'b0;
    if (stop_det)
    begin
      state_next = ST_IDLE;
      oe_next = 1'b0;
    end
    else if (start_det)
    begin
      // Pointer survives a repeated START
      state_next = ST_ADDR;
      bitcnt_next = 4'h0;
      oe_next = 1'b0;
    end
    else
    begin
      case (state_reg)
        ST_ADDR, ST_PTR, ST_WDATA:
        begin
          if (scl_rise && !byte_done)
          begin
            shift_next = {shift_reg[6:0], pins_s.sda};
            bitcnt_next = bitcnt_reg + 4'h1;
          end
          else if (scl_fall && byte_done)
          begin
            bitcnt_next = 4'h0;
            oe_next = 1'b1;
            if (state_reg == ST_ADDR)
            begin
              if (addr_match)
                state_next = ST_ADDR_ACK;
              else
              begin
                state_next = ST_IGNORE;
                oe_next = 1'b0;
              end
            end
            else if (state_reg == ST_PTR)
            begin
              ptr_next = shift_reg;
              state_next = ST_PTR_ACK;
            end
            else
            begin
              wr_en = 1'b1;
              ptr_next = ptr_inc;
              state_next = ST_WDATA_ACK;
            end
          end
        end
        ST_ADDR_ACK:
        begin
          if (scl_fall)
          begin
            if (rw_read)
            begin
              tx_next = rd_data;
              oe_next = ~rd_data[7];
              state_next = ST_RDATA;
            end
            else
            begin
              oe_next = 1'b0;
              state_next = ST_PTR;
            end
          end
        end
        ST_PTR_ACK, ST_WDATA_ACK:
        begin
          if (scl_fall)
          begin
            oe_next = 1'b0;
            state_next = ST_WDATA;
          end
        end
        ST_RDATA:
        begin
          if (scl_rise && !byte_done)
            bitcnt_next = bitcnt_reg + 4'h1;
          else if (scl_fall && byte_done)
          begin
            oe_next = 1'b0;
            state_next = ST_RACK;
          end
          else if (scl_fall)
          begin
            tx_next = {tx_reg[6:0], 1'b0};
            oe_next = ~tx_reg[6];
          end
        end
        ST_RACK:
        begin
          if (scl_rise)
          begin
            ack_next = ~pins_s.sda;
            ptr_next = ptr_inc;
          end
          else if (scl_fall)
          begin
            bitcnt_next = 4'h0;
            if (ack_reg)
            begin
              tx_next = rd_data;
              oe_next = ~rd_data[7];
              state_next = ST_RDATA;
            end
            else
            begin
              oe_next = 1'b0;
              state_next = ST_IGNORE;
            end
          end
        end
        ST_IDLE, ST_IGNORE:
        begin
          oe_next = 1'b0;
        end
        default:
        begin
          state_next = ST_IDLE;
          oe_next = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      pins_q <= '1;
      state_reg <= ST_IDLE;
      bitcnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      tx_reg <= 8'h00;
      ptr_reg <= PTR_RESET;
      oe_reg <= 1'b0;
      ack_reg <= 1'b0;
    end
    else
    begin
      pins_q <= pins_s;
      state_reg <= state_next;
      bitcnt_reg <= bitcnt_next;
      shift_reg <= shift_next;
      tx_reg <= tx_next;
      ptr_reg <= ptr_next;
      oe_reg <= oe_next;
      ack_reg <= ack_next;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  sequence s_addr_byte_end;
    !stop_det && !start_det && scl_fall && state_reg == ST_ADDR && byte_done;
  endsequence

  a_ack_address: assert property (s_addr_byte_end ##0 addr_match
    |=> sda_oe && state_reg == ST_ADDR_ACK)
    else $error("own address not acknowledged");

  a_foreign_quiet: assert property (s_addr_byte_end ##0 !addr_match
    |=> !sda_oe && state_reg == ST_IGNORE)
    else $error("foreign address answered");

  a_ptr_load: assert property (!stop_det && !start_det && scl_fall &&
    state_reg == ST_PTR && byte_done |=> ptr_reg == $past(shift_reg))
    else $error("pointer not loaded");

  a_ptr_step: assert property (wr_en |=> ptr_reg == $past(ptr_inc))
    else $error("pointer did not advance");

  a_ptr_wrap: assert property (wr_en && ptr_reg == 8'hFF |=> ptr_reg == 8'h00)
    else $error("pointer did not wrap");

  a_stop_idle: assert property (stop_det |=> state_reg == ST_IDLE && !sda_oe)
    else $error("stop did not end transaction");

  a_write_ack: assert property (wr_en |=> sda_oe [*1] ##0 state_reg == ST_WDATA_ACK)
    else $error("data byte not acknowledged");

  a_read_next: assert property (!stop_det && !start_det && scl_fall &&
    state_reg == ST_RACK && ack_reg |=> state_reg == ST_RDATA && sda_oe == ~$past(rd_msb))
    else $error("next read byte not driven");

  a_nack_release: assert property (!stop_det && !start_det && scl_fall &&
    state_reg == ST_RACK && !ack_reg |=> !sda_oe [*2])
    else $error("data line held after nack");

endmodule
`default_nettype wire

// ---- core/sip_reg_store.sv ----
// Byte register store: writable RAM bytes and a read-only factory region.
// Assumes writes and reads come from the port controller on the same clock.
`timescale 1ns/1ps
`default_nettype none
module sip_reg_store
  import sip_pkg::*;
#(
  parameter int unsigned NVM_SIZE = NVM_BYTES,
  // Factory image; default content is arbitrary
  parameter logic [NVM_BYTES*8-1:0] NVM_IMAGE = '0
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Write side
  input wire logic wr_en,
  input wire logic [7:0] wr_addr,
  input wire logic [7:0] wr_data,
  // Read side
  input wire logic [7:0] rd_addr,
  output logic [7:0] rd_data
);

  logic [7:0] ram_reg [0:255];

  function automatic logic in_nvm(input logic [7:0] a);
    in_nvm = (a >= NVM_BASE) && ({1'b0, a} < ({1'b0, NVM_BASE} + 9'(NVM_SIZE)));
  endfunction

  wire rd_is_nvm = in_nvm(rd_addr);
  wire [7:0] nvm_byte = NVM_IMAGE[8*(rd_addr - NVM_BASE) +: 8];
  // Factory region readable, RAM elsewhere
  assign rd_data = rd_is_nvm ? nvm_byte : ram_reg[rd_addr];

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      for (int i = 0; i < 256; i++)
        ram_reg[i] <= RAM_RESET;
    end
    else if (wr_en && !in_nvm(wr_addr))
      ram_reg[wr_addr] <= wr_data;
  end

  a_scratch_echo: assert property (@(posedge clk) disable iff (reset)
    wr_en && wr_addr >= SCRATCH_FIRST && wr_addr <= SCRATCH_LAST
    |=> ram_reg[$past(wr_addr)] == $past(wr_data))
    else $error("scratch byte not stored");

  a_nvm_readback: assert property (@(posedge clk) disable iff (reset)
    rd_is_nvm |-> rd_data == NVM_IMAGE[8*(rd_addr - NVM_BASE) +: 8])
    else $error("factory byte read wrong");

  a_nvm_fixed: assert property (@(posedge clk) disable iff (reset)
    rd_is_nvm && $stable(rd_addr) |-> $stable(rd_data))
    else $error("factory byte changed");

endmodule
`default_nettype wire

// ---- verification/sip_host_model.sv ----
// Bus master model: drives SCL and pulls SDA low for START, STOP and bits.
// Assumes SDA is resolved with a pull-up by the bench.
`timescale 1ns/1ps
`default_nettype none
module sip_host_model
(
  // Clock
  input wire logic clk,
  // Bus lines
  output logic scl,
  output logic sda_pull,
  input wire logic sda_line
);
  // Quarter bit time; 252-cycle SCL period stays below 400 kHz
  localparam int Q = 63;
  initial
  begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  task automatic qw();
    repeat (Q) @(negedge clk);
  endtask
  // Also serves as repeated START before the read address
  task automatic start();
    sda_pull = 1'b0;
    qw();
    scl = 1'b1;
    qw();
    sda_pull = 1'b1;
    qw();
    scl = 1'b0;
    qw();
  endtask
  task automatic stop();
    sda_pull = 1'b1;
    qw();
    scl = 1'b1;
    qw();
    sda_pull = 1'b0;
    qw();
  endtask
  task automatic bit_x(input logic b, output logic s);
    sda_pull = ~b;
    qw();
    scl = 1'b1;
    qw();
    s = sda_line;
    qw();
    scl = 1'b0;
    qw();
  endtask
  // Address, pointer or data byte, MSB first; ack is 1 when the target pulled SDA low
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_x(b[i], s);
    bit_x(1'b1, s);
    ack = ~s;
  endtask
  // Last byte of a burst is not acknowledged
  task automatic rbyte(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, b[i]);
    bit_x(last, s);
  endtask
endmodule
`default_nettype wire

// ---- verification/testbench.sv ----
// Self-checking bench for the sensor I2C register port.
// Assumes the host model file is compiled first.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import sip_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic scl;
  logic sda_pull;
  logic sda_o;
  logic sda_oe;
  logic selected;
  wire logic sda_line = !(sda_pull || (sda_oe && !sda_o));
  int n_mismatch = 0;
  int checks = 0;
  int cycles = 0;
  logic [7:0] pat [4] = '{8'h3C, 8'hA5, 8'h5A, 8'hC3};
  always #5 clk = ~clk;
  // Factory image: low half 0xA3, high half 0x5C, so offsets are told apart
  localparam logic [NVM_BYTES*8-1:0] NVM_TB = {{(NVM_BYTES/2){8'h5C}}, {(NVM_BYTES/2){8'hA3}}};
  sip_port #(.NVM_IMAGE(NVM_TB)) dut_u (
    .clk(clk), .reset(reset), .scl_i(scl), .sda_i(sda_line),
    .sda_o(sda_o), .sda_oe(sda_oe), .selected(selected));
  sip_host_model host_u (.clk(clk), .scl(scl), .sda_pull(sda_pull), .sda_line(sda_line));
  task automatic wrap_up();
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 100000)
    begin
      n_mismatch++;
      wrap_up();
    end
  end
  task automatic chk_b(input string w, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic chk_f(input string w, input logic e, input logic g);
    checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("Error %s expected %b seen %b", w, e, g);
    end
  endtask
  task automatic wb(input logic [7:0] b, input logic e);
    logic a;
    host_u.wbyte(b, a);
    chk_f("ack", e, a);
  endtask
  task automatic rb(input logic [7:0] e, input logic last);
    logic [7:0] v;
    host_u.rbyte(last, v);
    chk_b("read byte", e, v);
  endtask
  task automatic rd_at(input logic [7:0] p);
    host_u.start();
    wb({TARGET_ADDR, 1'b0}, 1'b1);
    chk_f("selected", 1'b1, selected);
    wb(p, 1'b1);
    host_u.start();
    wb({TARGET_ADDR, 1'b1}, 1'b1);
  endtask
  task automatic t_scratch();
    host_u.start();
    wb({TARGET_ADDR, 1'b0}, 1'b1);
    wb(8'h88, 1'b1);
    for (int i = 0; i < 4; i++) wb(pat[i], 1'b1);
    host_u.stop();
    rd_at(8'h88);
    for (int i = 0; i < 4; i++) rb(pat[i], i == 3);
    host_u.stop();
    chk_f("selected", 1'b0, selected);
    $display("Test scratch done");
  endtask
  task automatic t_other_addr();
    host_u.start();
    wb(8'h66, 1'b0);
    chk_f("selected", 1'b0, selected);
    host_u.stop();
    $display("Test other address done");
  endtask
  task automatic t_wrap();
    host_u.start();
    wb({TARGET_ADDR, 1'b0}, 1'b1);
    wb(8'hFF, 1'b1);
    wb(8'h22, 1'b1);
    wb(8'h33, 1'b1);
    rd_at(8'hFF);
    rb(8'h22, 1'b0);
    rb(8'hA3, 1'b1);
    host_u.stop();
    $display("Test wrap done");
  endtask
  task automatic t_factory();
    rd_at(NVM_ICEPT_OFS);
    rb(8'h5C, 1'b1);
    host_u.stop();
    $display("Test factory done");
  endtask
  task automatic t_stop();
    host_u.start();
    wb({TARGET_ADDR, 1'b0}, 1'b1);
    wb(8'h90, 1'b1);
    wb(8'h77, 1'b1);
    chk_f("selected", 1'b1, selected);
    host_u.stop();
    chk_f("selected", 1'b0, selected);
    host_u.start();
    wb({TARGET_ADDR, 1'b1}, 1'b1);
    rb(RAM_RESET, 1'b1);
    host_u.stop();
    rd_at(8'h90);
    rb(8'h77, 1'b1);
    host_u.stop();
    $display("Test stop done");
  endtask
  initial
  begin
    repeat (4) @(negedge clk);
    reset = 1'b0;
    t_scratch();
    t_other_addr();
    t_wrap();
    t_factory();
    t_stop();
    wrap_up();
  end
endmodule
`default_nettype wire
